// [hdl/ccr_pkg.sv]
// Shared constants for the calendar clock register interface.
package ccr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIME = 8'h04;
  localparam logic [7:0] OFF_ALCFG = 8'h08;
  localparam logic [7:0] OFF_ALARM = 8'h0C;
  localparam logic [7:0] OFF_KEY = 8'h10;
  localparam logic [7:0] OFF_SRC = 8'h14;
  localparam logic [7:0] WORD_MASK = 8'hFC;

  // Control and calibration register fields.
  localparam int CTL_EN_BIT = 15;
  localparam int CTL_WREN_BIT = 13;
  localparam int CTL_SYNC_BIT = 12;
  localparam int CTL_HALF_BIT = 11;
  localparam int CTL_OE_BIT = 10;
  localparam int CTL_PTR_LSB = 8;
  localparam logic [7:0] CAL_RST = 8'h00;
  localparam logic [1:0] PTR_RST = 2'h0;

  // Alarm configuration register fields.
  localparam int AL_EN_BIT = 15;
  localparam int AL_CHIME_BIT = 14;
  localparam int AL_MASK_LSB = 10;
  localparam int AL_PTR_LSB = 8;

  // Clock source register field and its power-on value.
  localparam int SRC_SEL_BIT = 0;
  localparam logic SRC_RST = 1'b1;

  // Unlock key sequence.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Window pointer values.
  localparam logic [1:0] PTR_MINUTES_SECONDS_VALUE = 2'h0;
  localparam logic [1:0] PTR_WDHR = 2'h1;
  localparam logic [1:0] PTR_MTHDY = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;

  // Alarm interval encodings.
  localparam logic [3:0] AM_HALF = 4'h0;
  localparam logic [3:0] AM_SEC = 4'h1;
  localparam logic [3:0] AM_TENSEC = 4'h2;
  localparam logic [3:0] AM_MIN = 4'h3;
  localparam logic [3:0] AM_TENMIN = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;

  // Reference timing: half a second is half the reference rate in pulses.
  localparam int REF_HZ = 32768;
  localparam int HALF_DIV = REF_HZ / 2;
  localparam logic [13:0] HALF_LAST = 14'(HALF_DIV - 1);
  localparam int RIPPLE_PULSES = 32;
  localparam logic [13:0] RIPPLE_START = 14'(HALF_DIV - RIPPLE_PULSES);

  // Power-on calendar value: 2000-01-01 00:00:00, weekday 0.
  localparam logic [7:0] DAY_RST = 8'h01;
  localparam logic [7:0] MON_RST = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} ccr_key_e;
endpackage : ccr_pkg

// [hdl/ccr_calendar_clock.sv]
// Calendar clock with calibration, value windows, alarm and register slave.
//
// Contract
// - Calendar and reference keep counting through external master reset.
// - Source bit 1 selects crystal oscillator, 0 selects low-power RC.
// - Time window pointer maps min/sec, weekday/hour, month/day, year.
// - Writing time window high byte decrements pointer, stopping at 00.
// - Alarm window pointer maps min/sec, weekday/hour, month/day; 11 empty.
// - Writing alarm window high byte decrements alarm pointer, stopping at 00.
// - Any window read decrements its pointer; low-byte writes do not.
// - Time writes accepted only while write-enable bit 13 is set.
// - Write-enable may be set only right after 55h then AAh key writes.
// - Bit 15 enables calendar; writable only while write-enable is 1.
// - Bit 12 reads 1 near rollover; software reads twice to confirm.
// - Bit 11 shows second half of second; minutes_seconds_value low write clears it.
// - Bit 10 enables the calendar output pin.
// - Bit 14 reads zero; bits 7..0 are calibration, reset zero.
// - Control and calibration register is reset only at power-on.
// - Hours count in 24-hour format, wrapping 23 to 00.
// - Leap-year February for 2000..2099; track weekday, day, month, year.
// - Time, date and alarm values are held in BCD.
// - Alarm fires per half second up to once per year.
// - Alarm repeat counter decrements per event; chime repeats forever.
// - Calibration adds or removes reference pulses periodically.
// - Calibration is signed; each step is 4 pulses per minute.
// - Alarm enable auto-clears at zero count without chime; with chime the count wraps 00 to FF.
// - Interval field codes 0000 half second through 1001 year.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ccr_calendar_clock (
  // Clock and power-on reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // External pins.
  input wire logic external_master_reset_n,
  input wire logic secondary_crystal_osc,
  input wire logic low_power_rc_osc,
  output logic calendar_out,
  output logic calendar_out_oe,
  output logic alarm_event,
  // Register bus write channels.
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ccr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read channels.
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ccr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ccr_pkg::*;

  // Pin synchronisers: master reset, crystal, RC oscillator.
  localparam logic [2:0] SYNC_RST = 3'h1;
  wire logic [2:0] pin_raw;
  wire logic [2:0] pin_lvl;
  assign pin_raw = {low_power_rc_osc, secondary_crystal_osc, external_master_reset_n};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          s1 <= SYNC_RST[gi];
          s2 <= SYNC_RST[gi];
          s3 <= SYNC_RST[gi];
          lvl <= SYNC_RST[gi];
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
      assign pin_lvl[gi] = lvl;
    end
  endgenerate

  // Master reset touches only the bus slave and the unlock sequence.
  logic bus_rst;
  assign bus_rst = !reset_n || !pin_lvl[0];

  // Registers.
  logic cal_en;
  logic wren;
  logic out_en;
  logic [1:0] time_ptr;
  logic [7:0] cal;
  logic src_sel;
  logic al_en;
  logic chime;
  logic [3:0] alarm_interval_select;
  logic [1:0] aptr;
  logic [7:0] alarm_repeat_count;
  logic [7:0] sec, min, hr, wd, day, mon, yr;
  logic [7:0] asec, amin, ahr, awd, aday, amon;
  ccr_key_e key_state;

  // Bus write path: address and data are taken independently.
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic do_write;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (bus_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  logic [7:0] wa;
  logic wr_ctrl, wr_time, wr_alcfg, wr_alarm, wr_key, wr_src, wr_hit, wr_hi, wr_lo;
  assign wa = aw_q & WORD_MASK;
  assign wr_hi = ws_q[1];
  assign wr_lo = ws_q[0];
  assign wr_ctrl = do_write && wa == OFF_CTRL;
  assign wr_time = do_write && wa == OFF_TIME && wren;
  assign wr_alcfg = do_write && wa == OFF_ALCFG;
  assign wr_alarm = do_write && wa == OFF_ALARM;
  assign wr_key = do_write && wa == OFF_KEY && wr_lo;
  assign wr_src = do_write && wa == OFF_SRC && wr_lo;
  assign wr_hit = wa == OFF_CTRL || wa == OFF_TIME || wa == OFF_ALCFG || wa == OFF_ALARM ||
                  wa == OFF_KEY || wa == OFF_SRC;

  always_ff @(posedge clk_sys) begin
    if (bus_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unlock sequence: the key pair opens the lock for the next bus write only.
  always_ff @(posedge clk_sys) begin
    if (bus_rst) begin
      key_state <= KEY_IDLE;
    end else if (wr_key && wd_q[7:0] == KEY_FIRST) begin
      key_state <= KEY_HALF;
    end else if (wr_key && key_state == KEY_HALF && wd_q[7:0] == KEY_SECOND) begin
      key_state <= KEY_OPEN;
    end else if (do_write) begin
      key_state <= KEY_IDLE;
    end
  end

  // Bus read path.
  logic rd_take, rd_time, rd_alarm;
  logic [7:0] ra;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign ra = s_axi_araddr & WORD_MASK;
  assign rd_time = rd_take && ra == OFF_TIME;
  assign rd_alarm = rd_take && ra == OFF_ALARM;

  // Prescaler, calibration and half-second state.
  logic ref_prev, ref_lvl, ref_edge;
  logic [13:0] prescale;
  logic [9:0] cal_left;
  logic cal_add;
  logic half_sec, half_tick, sec_tick;
  logic swallow, extra, count_pulse;
  logic minutes_seconds_value_lo_wr;
  assign ref_lvl = src_sel ? pin_lvl[1] : pin_lvl[2];
  assign ref_edge = ref_lvl && !ref_prev;
  assign swallow = ref_edge && cal_left != 10'h000 && !cal_add;
  assign extra = !ref_edge && cal_left != 10'h000 && cal_add;
  assign count_pulse = cal_en && ((ref_edge && !swallow) || extra);
  assign half_tick = count_pulse && prescale == HALF_LAST;
  assign sec_tick = half_tick && half_sec;
  assign minutes_seconds_value_lo_wr = wr_time && time_ptr == PTR_MINUTES_SECONDS_VALUE && wr_lo;

  logic [7:0] day_max;
  logic leap, sec_wrap, min_wrap, hr_wrap, day_wrap, mon_wrap;
  assign leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
  always_comb begin
    case (mon)
      8'h02: day_max = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: day_max = 8'h30;
      default: day_max = 8'h31;
    endcase
  end
  assign sec_wrap = sec == 8'h59;
  assign min_wrap = min == 8'h59;
  assign hr_wrap = hr == 8'h23;
  assign day_wrap = day == day_max;
  assign mon_wrap = mon == 8'h12;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction : bcd_inc

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ref_prev <= 1'b0;
      prescale <= '0;
      half_sec <= 1'b0;
    end else begin
      ref_prev <= ref_lvl;
      if (minutes_seconds_value_lo_wr) begin
        prescale <= '0;
        half_sec <= 1'b0;
      end else if (count_pulse) begin
        prescale <= half_tick ? 14'h0000 : 14'(prescale + 14'h0001);
        half_sec <= half_sec ^ half_tick;
      end
    end
  end

  // Once a minute the signed step count times four is loaded.
  logic [7:0] cal_mag;
  assign cal_mag = cal[7] ? 8'(~cal + 8'h01) : cal;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cal_left <= '0;
      cal_add <= 1'b0;
    end else if (sec_tick && sec_wrap) begin
      cal_left <= {cal_mag, 2'b00};
      cal_add <= !cal[7];
    end else if (swallow || (extra && cal_en)) begin
      cal_left <= 10'(cal_left - 10'h001);
    end
  end

  // Calendar counters; a software write wins over a tick in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sec <= '0;
      min <= '0;
      hr <= '0;
      wd <= '0;
      day <= DAY_RST;
      mon <= MON_RST;
      yr <= '0;
    end else if (wr_time) begin
      case (time_ptr)
        PTR_MINUTES_SECONDS_VALUE: begin
          if (wr_hi) min <= {1'b0, wd_q[14:8]};
          if (wr_lo) sec <= {1'b0, wd_q[6:0]};
        end
        PTR_WDHR: begin
          if (wr_hi) wd <= {5'h00, wd_q[10:8]};
          if (wr_lo) hr <= {2'h0, wd_q[5:0]};
        end
        PTR_MTHDY: begin
          if (wr_hi) mon <= {3'h0, wd_q[12:8]};
          if (wr_lo) day <= {2'h0, wd_q[5:0]};
        end
        default: begin
          if (wr_lo) yr <= wd_q[7:0];
        end
      endcase
    end else if (sec_tick) begin
      sec <= sec_wrap ? 8'h00 : bcd_inc(sec);
      if (sec_wrap) begin
        min <= min_wrap ? 8'h00 : bcd_inc(min);
        if (min_wrap) begin
          hr <= hr_wrap ? 8'h00 : bcd_inc(hr);
          if (hr_wrap) begin
            wd <= wd == 8'h06 ? 8'h00 : 8'(wd + 8'h01);
            day <= day_wrap ? DAY_RST : bcd_inc(day);
            if (day_wrap) begin
              mon <= mon_wrap ? MON_RST : bcd_inc(mon);
              if (mon_wrap) yr <= yr == 8'h99 ? 8'h00 : bcd_inc(yr);
            end
          end
        end
      end
    end
  end

  // Control register; only the power-on reset clears it.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cal_en <= 1'b0;
      wren <= 1'b0;
      out_en <= 1'b0;
      time_ptr <= PTR_RST;
      cal <= CAL_RST;
      src_sel <= SRC_RST;
    end else begin
      if (wr_ctrl && wr_hi) begin
        if (wren) cal_en <= wd_q[CTL_EN_BIT];
        if (!wd_q[CTL_WREN_BIT] || key_state == KEY_OPEN) wren <= wd_q[CTL_WREN_BIT];
        out_en <= wd_q[CTL_OE_BIT];
        time_ptr <= wd_q[CTL_PTR_LSB+:2];
      end else if ((rd_time || (wr_time && wr_hi)) && time_ptr != PTR_MINUTES_SECONDS_VALUE) begin
        time_ptr <= 2'(time_ptr - 2'h1);
      end
      if (wr_ctrl && wr_lo) cal <= wd_q[7:0];
      if (wr_src) src_sel <= wd_q[SRC_SEL_BIT];
    end
  end

  // Alarm matching runs one cycle after the tick, on the updated time.
  logic chk_half, chk_sec, hit, fire;
  logic m_s1, m_s, m_m1, m_m, m_h, m_w, m_d, m_mo;
  assign m_s1 = sec[3:0] == asec[3:0];
  assign m_s = sec == asec;
  assign m_m1 = min[3:0] == amin[3:0];
  assign m_m = min == amin;
  assign m_h = hr == ahr;
  assign m_w = wd == awd;
  assign m_d = day == aday;
  assign m_mo = mon == amon;
  always_comb begin
    case (alarm_interval_select)
      AM_HALF: hit = chk_half;
      AM_SEC: hit = chk_sec;
      AM_TENSEC: hit = chk_sec && m_s1;
      AM_MIN: hit = chk_sec && m_s;
      AM_TENMIN: hit = chk_sec && m_s && m_m1;
      AM_HOUR: hit = chk_sec && m_s && m_m;
      AM_DAY: hit = chk_sec && m_s && m_m && m_h;
      AM_WEEK: hit = chk_sec && m_s && m_m && m_h && m_w;
      AM_MONTH: hit = chk_sec && m_s && m_m && m_h && m_d;
      AM_YEAR: hit = chk_sec && m_s && m_m && m_h && m_d && m_mo;
      default: hit = 1'b0;
    endcase
  end
  assign fire = al_en && hit;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      chk_half <= 1'b0;
      chk_sec <= 1'b0;
      alarm_event <= 1'b0;
      calendar_out <= 1'b0;
      calendar_out_oe <= 1'b0;
    end else begin
      chk_half <= half_tick;
      chk_sec <= sec_tick;
      alarm_event <= fire;
      calendar_out <= calendar_out ^ fire;
      calendar_out_oe <= out_en;
    end
  end

  // Alarm configuration; a software write wins over the event update.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      al_en <= 1'b0;
      chime <= 1'b0;
      alarm_interval_select <= AM_HALF;
      aptr <= PTR_RST;
      alarm_repeat_count <= '0;
    end else begin
      if (wr_alcfg && wr_hi) begin
        al_en <= wd_q[AL_EN_BIT];
        chime <= wd_q[AL_CHIME_BIT];
        alarm_interval_select <= wd_q[AL_MASK_LSB+:4];
        aptr <= wd_q[AL_PTR_LSB+:2];
      end else begin
        if (fire && alarm_repeat_count == 8'h00 && !chime) al_en <= 1'b0;
        if ((rd_alarm || (wr_alarm && wr_hi)) && aptr != PTR_MINUTES_SECONDS_VALUE) begin
          aptr <= 2'(aptr - 2'h1);
        end
      end
      if (wr_alcfg && wr_lo) begin
        alarm_repeat_count <= wd_q[7:0];
      end else if (fire && (alarm_repeat_count != 8'h00 || chime)) begin
        alarm_repeat_count <= 8'(alarm_repeat_count - 8'h01);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      asec <= '0;
      amin <= '0;
      ahr <= '0;
      awd <= '0;
      aday <= '0;
      amon <= '0;
    end else if (wr_alarm) begin
      case (aptr)
        PTR_MINUTES_SECONDS_VALUE: begin
          if (wr_hi) amin <= {1'b0, wd_q[14:8]};
          if (wr_lo) asec <= {1'b0, wd_q[6:0]};
        end
        PTR_WDHR: begin
          if (wr_hi) awd <= {5'h00, wd_q[10:8]};
          if (wr_lo) ahr <= {2'h0, wd_q[5:0]};
        end
        PTR_MTHDY: begin
          if (wr_hi) amon <= {3'h0, wd_q[12:8]};
          if (wr_lo) aday <= {2'h0, wd_q[5:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Read data mux.
  logic ripple;
  logic [15:0] ctrl_rd, time_rd, alarm_rd, rd16;
  assign ripple = half_sec && prescale >= RIPPLE_START;
  always_comb begin
    ctrl_rd = {cal_en, 1'b0, wren, ripple, half_sec, out_en, time_ptr, cal};
    case (time_ptr)
      PTR_MINUTES_SECONDS_VALUE: time_rd = {min, sec};
      PTR_WDHR: time_rd = {wd, hr};
      PTR_MTHDY: time_rd = {mon, day};
      default: time_rd = {8'h00, yr};
    endcase
    case (aptr)
      PTR_MINUTES_SECONDS_VALUE: alarm_rd = {amin, asec};
      PTR_WDHR: alarm_rd = {awd, ahr};
      PTR_MTHDY: alarm_rd = {amon, aday};
      default: alarm_rd = 16'h0000;
    endcase
    case (ra)
      OFF_CTRL: rd16 = ctrl_rd;
      OFF_TIME: rd16 = time_rd;
      OFF_ALCFG: rd16 = {al_en, chime, alarm_interval_select, aptr, alarm_repeat_count};
      OFF_ALARM: rd16 = alarm_rd;
      OFF_SRC: rd16 = {15'h0000, src_sel};
      default: rd16 = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (bus_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd16};
      s_axi_rresp <= (ra == OFF_CTRL || ra == OFF_TIME || ra == OFF_ALCFG || ra == OFF_ALARM ||
                      ra == OFF_KEY || ra == OFF_SRC) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ccr_calendar_clock
`default_nettype wire

// [sim/ccr_calendar_clock_props.sv]
// Checker for the register bus handshakes and the calendar output enable.
`timescale 1ns/1ps
`default_nettype none
module ccr_calendar_clock_props (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched ports.
  input wire logic calendar_out_oe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ccr_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ccr_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr & WORD_MASK) > OFF_SRC |=> s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == '0) else $error("unmapped read not refused");
  a_ctrl_gap: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CTRL |=> !s_axi_rdata[14])
    else $error("control bit 14 not zero");
  a_oe_follow: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CTRL
    |=> calendar_out_oe == s_axi_rdata[CTL_OE_BIT]) else $error("output enable mismatch");
endmodule : ccr_calendar_clock_props
`default_nettype wire

// [sim/ccr_calendar_clock_tb.sv]
// Self-checking bench for the calendar clock register interface.
`timescale 1ns/1ps
`default_nettype none
module ccr_calendar_clock_tb;
  import ccr_pkg::*;
  logic clk_sys = 0, reset_n = 0, ext_rst_n = 1, xosc = 0, rcosc = 0, osc_run = 0;
  logic cal_out, cal_oe, alarm_ev, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = '0, araddr = '0, yr, mo, dy, wd, hr, mi, se, cal;
  logic [2:0] awprot = '0, arprot = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] tv [4];
  int fail_count = 0, comparisons = 0, n, alarms = 0;
  time t0;
  always #2.5 clk_sys = ~clk_sys;
  always #10 xosc = osc_run & ~xosc;
  always #15 rcosc = ~rcosc;
  always @(posedge clk_sys) if (alarm_ev === 1'b1) alarms++;
  ccr_calendar_clock u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .external_master_reset_n(ext_rst_n), .secondary_crystal_osc(xosc),
    .low_power_rc_osc(rcosc), .calendar_out(cal_out), .calendar_out_oe(cal_oe),
    .alarm_event(alarm_ev), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic finish_test();
    $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awprot <= 3'($urandom);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom_range(1));
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
    araddr <= a;
    arprot <= 3'($urandom);
    arvalid <= 1'b1;
    rready <= 1'($urandom_range(1));
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
    if (m != "") chk(v, e, m);
  endtask : rc
  task automatic wc(input logic [15:0] d);
    wr(OFF_KEY, 32'(KEY_FIRST), 4'h1);
    wr(OFF_KEY, 32'(KEY_SECOND), 4'h1);
    wr(OFF_CTRL, 32'(d), 4'h3);
  endtask : wc
  function automatic logic [7:0] bcd(input int x);
    return 8'((x / 10) * 16 + x % 10);
  endfunction : bcd
  initial begin
    #450000;
    fail_count++;
    finish_test();
  end
  initial begin
    n = $urandom(53);
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rc(OFF_CTRL, 32'h0, "control reset");
    rc(OFF_SRC, 32'(SRC_RST), "source reset");
    rc(8'h18, 32'h0, "unmapped read");
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped resp");
    wr(OFF_CTRL, 32'hA000, 4'h3);
    rc(OFF_CTRL, 32'h0, "locked enable");
    wr(OFF_TIME, 32'h5959, 4'h3);
    rc(OFF_TIME, 32'h0, "locked time");
    cal = 8'($urandom);
    yr = bcd($urandom_range(99));
    mo = 8'h12;
    dy = 8'h31;
    wd = bcd($urandom_range(6));
    hr = bcd($urandom_range(23));
    mi = bcd($urandom_range(59));
    se = bcd($urandom_range(59));
    tv = '{{8'h00, yr}, {mo, dy}, {wd, hr}, {mi, se}};
    wc({8'h67, cal});
    rc(OFF_CTRL, {16'h0, 8'h27, cal}, "control write");
    chk(32'(cal_oe), 32'h1, "output enable");
    for (int i = 0; i < 5; i++) begin
      wr(OFF_TIME, 32'(tv[(i > 3) ? 3 : i]), 4'h3);
    end
    rc(OFF_CTRL, {16'h0, 8'h24, cal}, "pointer floor");
    wc({8'h27, cal});
    for (int i = 0; i < 4; i++) begin
      rc(OFF_TIME, 32'(tv[i]), "time window");
    end
    rc(OFF_CTRL, {16'h0, 8'h24, cal}, "read pointer");
    wc({8'h25, cal});
    hr = 8'h23;
    wr(OFF_TIME, {24'h0, hr}, 4'h1);
    rc(OFF_CTRL, {16'h0, 8'h25, cal}, "low write pointer");
    rc(OFF_TIME, {16'h0, wd, hr}, "hour write");
    wr(OFF_ALCFG, 32'h0300, 4'h3);
    rc(OFF_ALARM, 32'h0, "alarm empty slot");
    rc(OFF_ALCFG, 32'h0200, "alarm read pointer");
    for (int i = 1; i < 4; i++) begin
      wr(OFF_ALARM, 32'(tv[i]), 4'h3);
    end
    rc(OFF_ALCFG, 32'h0, "alarm pointer floor");
    wr(OFF_ALCFG, 32'h0200, 4'h3);
    for (int i = 1; i < 4; i++) begin
      rc(OFF_ALARM, 32'(tv[i]), "alarm window");
    end
    for (int i = 0; i < 10; i++) begin
      wr(OFF_ALCFG, 32'(i << 10) | 32'(cal), 4'h3);
      rc(OFF_ALCFG, 32'(i << 10) | 32'(cal), "interval code");
    end
    wr(OFF_CTRL, {16'h0, 8'h04, cal}, 4'h3);
    wr(OFF_TIME, 32'h0, 4'h3);
    rc(OFF_TIME, 32'(tv[3]), "time after lock");
    ext_rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    ext_rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rc(OFF_CTRL, {16'h0, 8'h04, cal}, "control kept");
    rc(OFF_TIME, 32'(tv[3]), "time kept");
    rc(OFF_TIME, 32'(tv[3]), "time reread");
    wc(16'h2000);
    wr(OFF_CTRL, 32'hA000, 4'h3);
    wr(OFF_ALCFG, 32'h8001, 4'h3);
    osc_run <= 1'b1;
    t0 = $time;
    rc(OFF_CTRL, 32'hA000, "first half");
    do begin
      rc(OFF_CTRL, 32'h0, "");
    end while (v[CTL_HALF_BIT] !== 1'b1 && $time - t0 < 400000);
    n = int'(($time - t0) / 5);
    chk(32'(n >= 65000 && n <= 66000), 32'h1, "half second span");
    wr(OFF_TIME, 32'h0, 4'h1);
    rc(OFF_CTRL, 32'h0, "");
    chk(32'(v[CTL_HALF_BIT]), 32'h0, "half second clear");
    rc(OFF_ALCFG, 32'h8000, "repeat count");
    chk(32'(alarms), 32'h1, "alarm pulses");
    chk(32'(cal_out), 32'h1, "alarm output");
    osc_run <= 1'b0;
    finish_test();
  end
endmodule : ccr_calendar_clock_tb
bind ccr_calendar_clock ccr_calendar_clock_props u_props (.clk_sys(clk_sys),
  .reset_n(reset_n), .calendar_out_oe(calendar_out_oe), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
